// ### rtl/ccpu_pkg.sv
// package for the capture/compare/pwm unit: offsets, reset values,
// field positions, mode codes and the structs that join the two modules.
// assumes one 250 MHz clock and an 8-bit register port.
`default_nettype none
package ccpu_pkg;
	// register offsets, plain 8-bit register port
	localparam logic [7:0] OFF_PERIPHERAL_IRQ_FLAGS_ONE      = 8'h0C;
	localparam logic [7:0] OFF_FLAGS_TWO = 8'h0D;
	localparam logic [7:0] OFF_TIMER_TWO_COUNT      = 8'h11;
	localparam logic [7:0] OFF_TIMER_TWO_CONTROL     = 8'h12;
	localparam logic [7:0] OFF_PERIPHERAL_IRQ_ENABLES_ONE      = 8'h8C;
	localparam logic [7:0] OFF_PR2       = 8'h92;
	localparam logic [7:0] OFF_CH_LO [2] = '{8'h15, 8'h1B};
	localparam logic [7:0] OFF_CH_HI [2] = '{8'h16, 8'h1C};
	localparam logic [7:0] OFF_CH_CON[2] = '{8'h17, 8'h1D};
	// reset values
	localparam logic [7:0] RST_PERIPHERAL_IRQ_FLAGS_ONE  = 8'h00;
	localparam logic [7:0] RST_PERIPHERAL_IRQ_ENABLES_ONE  = 8'h00;
	localparam logic [7:0] RST_TIMER_TWO_COUNT  = 8'h00;
	localparam logic [6:0] RST_TIMER_TWO_CONTROL = 7'h00;
	localparam logic [7:0] RST_PR2   = 8'hFF;
	localparam logic [5:0] RST_CON   = 6'h00;
	// field positions
	localparam int PERIPHERAL_IRQ_FLAGS_ONE_CH1_BIT   = 2;
	localparam int PERIPHERAL_IRQ_FLAGS_ONE_T2_BIT    = 1;
	localparam int TIMER_TWO_CONTROL_ON_BIT   = 2;
	localparam int TIMER_TWO_CONTROL_POST_LSB = 3;
	localparam int CON_DUTY_LSB   = 4;
	// timer two prescale terminal counts (1:1, 1:4, 1:16)
	localparam logic [3:0] PRE_TERM_1  = 4'h0;
	localparam logic [3:0] PRE_TERM_4  = 4'h3;
	localparam logic [3:0] PRE_TERM_16 = 4'hF;
	localparam logic [1:0] PHASE_LAST  = 2'h3;
	// channel mode codes
	localparam logic [3:0] MODE_CAP_FALL = 4'h4;
	localparam logic [3:0] MODE_CAP_4TH  = 4'h6;
	localparam logic [3:0] MODE_CAP_16TH = 4'h7;
	localparam logic [3:0] MODE_CMP_SET  = 4'h8;
	localparam logic [3:0] MODE_CMP_CLR  = 4'h9;
	localparam logic [3:0] MODE_CMP_SPEV = 4'hB;
	// capture prescale terminal counts
	localparam logic [3:0] CAP_TERM_4  = 4'h3;
	localparam logic [3:0] CAP_TERM_16 = 4'hF;
	// channel operating kind, one-hot
	typedef enum logic [3:0] {
		KIND_OFF  = 4'b0001,
		KIND_CAPT = 4'b0010,
		KIND_CMP  = 4'b0100,
		KIND_PWM  = 4'b1000
	} ccpu_kind_t;
	// shared time base handed to each channel
	typedef struct packed {
		logic [15:0] t1;       // timer one count
		logic [9:0]  t2x;      // timer two count with two low phase or prescaler bits
		logic        restart;  // period end pulse
	} ccpu_tbase_t;
	// register writes aimed at one channel
	typedef struct packed {
		logic       we_lo;
		logic       we_hi;
		logic       we_con;
		logic [7:0] data;
	} ccpu_chwr_t;
	// channel events, one-cycle pulses
	typedef struct packed {
		logic flag;  // capture or compare event
		logic spev;  // special event trigger
	} ccpu_chev_t;
	// mode field to operating kind
	function automatic ccpu_kind_t ccpu_kind(input logic [3:0] mode);
		case (mode[3:2])
			2'b01:   ccpu_kind = KIND_CAPT;
			2'b10:   ccpu_kind = KIND_CMP;
			2'b11:   ccpu_kind = KIND_PWM;
			default: ccpu_kind = KIND_OFF;
		endcase
	endfunction : ccpu_kind
endpackage : ccpu_pkg
`default_nettype wire

// ### rtl/ccpu_channel.sv
// one capture/compare/pwm channel: value pair, control, pin logic.
// assumes the pin level is asynchronous and the time base is shared from the unit.
`default_nettype none
module ccpu_channel
	import ccpu_pkg::*;
(
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	// register side
	input  wire ccpu_chwr_t  wr_i,
	output logic [7:0]       value_low_o,
	output logic [7:0]       value_high_o,
	output logic [5:0]       control_o,
	// time base and pin
	input  wire ccpu_tbase_t tb_i,
	input  wire logic        pin_i,
	output logic             pin_o,
	output ccpu_chev_t       ev_o
);
	// all channel state
	typedef struct packed {
		logic [2:0] sync;   // pin synchroniser
		logic       lvl;    // accepted pin level
		logic [3:0] pre;    // capture edge counter
		logic [7:0] lo;     // value low byte
		logic [7:0] hi;     // value high byte
		logic [5:0] con;    // duty low bits and mode field
		logic [1:0] dlat;   // latched duty low bits
		logic       out;    // output latch
		logic       match;  // compare equal last cycle
		ccpu_chev_t ev;     // event pulses
	} ccpu_chst_t;
	localparam ccpu_chst_t CH_RST = '{con: RST_CON, default: '0};
	ccpu_chst_t q, d;
	ccpu_kind_t kind;       // decoded mode
	logic       edge_hit;   // qualifying pin edge
	logic       capt;       // capture now
	logic [3:0] term;       // edge count terminal

	// next state of the channel
	always_comb begin
		d = q;
		d.ev = '0;
		kind = ccpu_kind(q.con[3:0]);
		d.sync = {q.sync[1:0], pin_i};
		if (q.sync[2] == q.sync[1]) begin
			d.lvl = q.sync[2];
		end
		// pad level, so port writes count
		edge_hit = (q.sync[2] == q.sync[1]) && (q.sync[2] != q.lvl)
			&& ((q.con[3:0] == MODE_CAP_FALL) ? !q.sync[2] : q.sync[2]);
		term = (q.con[3:0] == MODE_CAP_4TH) ? CAP_TERM_4 : CAP_TERM_16;
		capt = 1'b0;
		if (wr_i.we_con) begin
			d.con = wr_i.data[5:0];
		end
		if (wr_i.we_lo) begin
			d.lo = wr_i.data;
		end
		if (wr_i.we_hi && kind != KIND_PWM) begin
			d.hi = wr_i.data;
		end
		case (kind)
			KIND_CAPT: begin
				if (edge_hit) begin
					if (q.con[3:1] == MODE_CAP_4TH[3:1]) begin
						d.pre = (q.pre == term) ? 4'h0 : q.pre + 4'h1;
						capt = (q.pre == term);
					end else begin
						capt = 1'b1;
					end
				end
				if (capt) begin
					{d.hi, d.lo} = tb_i.t1;
					d.ev.flag = 1'b1;
				end
				d.match = 1'b0;
			end
			KIND_CMP: begin
				d.pre = 4'h0;
				d.match = (tb_i.t1 == {q.hi, q.lo});
				if (d.match && !q.match) begin
					d.ev.flag = 1'b1;
					if (q.con[3:0] == MODE_CMP_SET) begin
						d.out = 1'b1;
					end else if (q.con[3:0] == MODE_CMP_CLR) begin
						d.out = 1'b0;
					end else if (q.con[3:0] == MODE_CMP_SPEV) begin
						d.ev.spev = 1'b1;
					end
				end
			end
			KIND_PWM: begin
				d.pre = 4'h0;
				d.match = 1'b0;
				if (tb_i.restart) begin
					// duty from low byte plus two bits
					d.out = ({q.lo, q.con[5:4]} != 10'h000);
					d.hi = q.lo;
					d.dlat = q.con[5:4];
				end else if ({q.hi, q.dlat} == tb_i.t2x) begin
					d.out = 1'b0;
				end
			end
			default: begin
				d.pre = 4'h0;
				d.out = 1'b0;
				d.match = 1'b0;
			end
		endcase
	end

	// state register
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			q <= CH_RST;
		end else begin
			q <= d;
		end
	end

	assign value_low_o  = q.lo;
	assign value_high_o = q.hi;
	assign control_o    = q.con;
	assign pin_o        = q.out;
	assign ev_o         = q.ev;
endmodule : ccpu_channel
`default_nettype wire

// ### rtl/ccpu_unit.sv
// capture/compare/pwm unit top: register port, timer two time base,
// interrupt flag bytes and two channels.
// assumes timer one lives outside and honours the reset pulse; the
// converter start pulse goes to an outside converter.
//
// Behaviour
// - value held as low and high bytes
// - channel two same, except trigger action
// - capture/compare use timer one, pwm timer two
// - both pwm channels share timer two period
// - control bits seven and six read zero
// - pwm duty low bits from control
// - mode zero disables and resets channel
// - capture falling, rising, 4th, 16th rising
// - compare sets or clears pin, flags
// - software interrupt mode flags, pin untouched
// - trigger resets timer one; channel two's also starts converter
// - modes 11xx select pwm
// - capture copies timer one value
// - capture sets flag, software clears
// - new capture overwrites old value
// - pin writes may cause capture
// - reset clears timer two, period all ones
// - trigger never sets timer one flag
// - period end clears, sets pin unless duty is zero, latches
// - pin clears on ten-bit duty match
`default_nettype none
module ccpu_unit
	import ccpu_pkg::*;
(
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	// register port
	input  wire logic [7:0]  addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [7:0]  rdata_o,
	// timer one and converter
	input  wire logic [15:0] timer_one_count_i,
	input  wire logic        ad_enable_i,
	output logic             timer_one_reset_o,
	output logic             ad_start_o,
	// channel pins
	input  wire logic [1:0]  channel_pin_i,
	output logic      [1:0]  channel_pin_o
);
	// address match, used for every register
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	// all state of the top
	typedef struct packed {
		logic [7:0] peripheral_irq_flags_one;     // peripheral flag byte
		logic [7:0] peripheral_irq_enables_one;     // peripheral enable byte
		logic       flag2;    // channel two flag
		logic [7:0] timer_two_count;     // timer two count
		logic [6:0] timer_two_control;    // timer two control
		logic [7:0] pr2;      // timer two period
		logic [1:0] phase;    // instruction phase
		logic [3:0] pre;      // timer two prescaler
		logic [3:0] post;     // timer two postscaler
		logic [7:0] rdata;    // read data
		logic       t1rst;    // timer one reset pulse
		logic       adst;     // converter start pulse
	} ccpu_top_t;

	localparam ccpu_top_t TOP_RST = '{
		peripheral_irq_flags_one:  RST_PERIPHERAL_IRQ_FLAGS_ONE,
		peripheral_irq_enables_one:  RST_PERIPHERAL_IRQ_ENABLES_ONE,
		flag2: 1'b0,
		timer_two_count:  RST_TIMER_TWO_COUNT,
		timer_two_control: RST_TIMER_TWO_CONTROL,
		pr2:   RST_PR2,
		phase: 2'h0,
		pre:   4'h0,
		post:  4'h0,
		rdata: 8'h00,
		t1rst: 1'b0,
		adst:  1'b0
	};

	ccpu_top_t   q, d;          // top state and next value
	ccpu_tbase_t tb;            // shared time base
	ccpu_chwr_t  chwr [2];      // writes per channel
	ccpu_chev_t  chev [2];      // events per channel
	logic [7:0]  ch_lo  [2];    // channel low bytes
	logic [7:0]  ch_hi  [2];    // channel high bytes
	logic [5:0]  ch_con [2];    // channel control fields
	logic [1:0]  ch_pin;        // channel output latches
	logic        t2_on;         // timer two running
	logic [3:0]  pre_term;      // prescale terminal count
	logic [1:0]  t2_ext;        // two low bits below timer two
	logic        t2_tick;       // timer two increment
	logic [7:0]  rd_val;        // selected read value

	// timer two prescale decode and extension bits
	always_comb begin
		t2_on = q.timer_two_control[TIMER_TWO_CONTROL_ON_BIT];
		case (q.timer_two_control[1:0])
			2'b00: begin
				// 1:1, the phase bits extend the count
				pre_term = PRE_TERM_1;
				t2_ext   = q.phase;
			end
			2'b01: begin
				// 1:4, low prescaler bits extend
				pre_term = PRE_TERM_4;
				t2_ext   = q.pre[1:0];
			end
			default: begin
				// 1:16, high prescaler bits extend
				pre_term = PRE_TERM_16;
				t2_ext   = q.pre[3:2];
			end
		endcase
		t2_tick = t2_on && (q.phase == PHASE_LAST) && (q.pre == pre_term);
	end

	// time base shared by both channels
	always_comb begin
		tb.t1 = timer_one_count_i;
		tb.t2x = {q.timer_two_count, t2_ext};
		tb.restart = t2_tick && (q.timer_two_count == q.pr2);
	end

	// per-channel write decode
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			chwr[i].we_lo  = wr_i && hit(addr_i, OFF_CH_LO[i]);
			chwr[i].we_hi  = wr_i && hit(addr_i, OFF_CH_HI[i]);
			chwr[i].we_con = wr_i && hit(addr_i, OFF_CH_CON[i]);
			chwr[i].data   = wdata_i;
		end
	end

	// two identical channels
	generate
		for (genvar g = 0; g < 2; g++) begin : g_chan
			ccpu_channel u_chan (
				.mclk_i       (mclk_i),
				.rst_n_i      (rst_n_i),
				.wr_i         (chwr[g]),
				.value_low_o  (ch_lo[g]),
				.value_high_o (ch_hi[g]),
				.control_o    (ch_con[g]),
				.tb_i         (tb),
				.pin_i        (channel_pin_i[g]),
				.pin_o        (ch_pin[g]),
				.ev_o         (chev[g])
			);
		end
	endgenerate

	// read multiplexer, unmapped reads zero
	always_comb begin
		rd_val = 8'h00;
		if (hit(addr_i, OFF_PERIPHERAL_IRQ_FLAGS_ONE)) begin
			rd_val = q.peripheral_irq_flags_one;
		end else if (hit(addr_i, OFF_FLAGS_TWO)) begin
			rd_val = {7'h00, q.flag2};
		end else if (hit(addr_i, OFF_PERIPHERAL_IRQ_ENABLES_ONE)) begin
			rd_val = q.peripheral_irq_enables_one;
		end else if (hit(addr_i, OFF_TIMER_TWO_COUNT)) begin
			rd_val = q.timer_two_count;
		end else if (hit(addr_i, OFF_TIMER_TWO_CONTROL)) begin
			// top bit unimplemented
			rd_val = {1'b0, q.timer_two_control};
		end else if (hit(addr_i, OFF_PR2)) begin
			rd_val = q.pr2;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (hit(addr_i, OFF_CH_LO[i])) begin
					rd_val = ch_lo[i];
				end
				if (hit(addr_i, OFF_CH_HI[i])) begin
					rd_val = ch_hi[i];
				end
				if (hit(addr_i, OFF_CH_CON[i])) begin
					rd_val = {2'b00, ch_con[i]};
				end
			end
		end
	end

	// next state of the top
	always_comb begin
		d = q;
		// read data valid only the cycle after the strobe
		d.rdata = rd_i ? rd_val : 8'h00;

		// phase runs while timer two is on
		if (t2_on) begin
			d.phase = q.phase + 2'h1;
			if (q.phase == PHASE_LAST) begin
				d.pre = (q.pre == pre_term) ? 4'h0 : q.pre + 4'h1;
			end
		end

		// timer two count and period end
		if (t2_tick) begin
			if (q.timer_two_count == q.pr2) begin
				// clear on the increment after match
				d.timer_two_count = 8'h00;
				// postscaled period ends set the timer two flag
				if (q.post == q.timer_two_control[6:TIMER_TWO_CONTROL_POST_LSB]) begin
					d.post = 4'h0;
				end else begin
					d.post = q.post + 4'h1;
				end
			end else begin
				d.timer_two_count = q.timer_two_count + 8'h01;
			end
		end

		// software writes win over counting
		if (wr_i && hit(addr_i, OFF_TIMER_TWO_COUNT)) begin
			d.timer_two_count = wdata_i;
			d.pre  = 4'h0;
			d.post = 4'h0;
		end
		if (wr_i && hit(addr_i, OFF_TIMER_TWO_CONTROL)) begin
			// count kept, scalers cleared
			d.timer_two_control = wdata_i[6:0];
			d.pre   = 4'h0;
			d.post  = 4'h0;
		end
		if (wr_i && hit(addr_i, OFF_PR2)) begin
			d.pr2 = wdata_i;
		end
		if (wr_i && hit(addr_i, OFF_PERIPHERAL_IRQ_ENABLES_ONE)) begin
			d.peripheral_irq_enables_one = wdata_i;
		end

		// flags cleared only by software writes
		if (wr_i && hit(addr_i, OFF_PERIPHERAL_IRQ_FLAGS_ONE)) begin
			d.peripheral_irq_flags_one = wdata_i;
		end
		if (wr_i && hit(addr_i, OFF_FLAGS_TWO)) begin
			d.flag2 = wdata_i[0];
		end
		if (chev[0].flag) begin
			d.peripheral_irq_flags_one[PERIPHERAL_IRQ_FLAGS_ONE_CH1_BIT] = 1'b1;
		end
		if (chev[1].flag) begin
			d.flag2 = 1'b1;
		end
		if (t2_tick && (q.timer_two_count == q.pr2) && (q.post == q.timer_two_control[6:TIMER_TWO_CONTROL_POST_LSB])) begin
			d.peripheral_irq_flags_one[PERIPHERAL_IRQ_FLAGS_ONE_T2_BIT] = 1'b1;
		end

		// timer one flag bit left alone
		d.t1rst = chev[0].spev || chev[1].spev;
		// only channel two starts the converter
		d.adst = chev[1].spev && ad_enable_i;
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			q <= TOP_RST;
		end else begin
			q <= d;
		end
	end

	// outputs straight from flip-flops
	assign rdata_o           = q.rdata;
	assign timer_one_reset_o = q.t1rst;
	assign ad_start_o        = q.adst;
	assign channel_pin_o     = ch_pin;
endmodule : ccpu_unit
`default_nettype wire

// ### verif/ccpu_unit_props.sv
// checker on the unit's top ports: register reads, trigger pulses, pins.
// assumes one clock and a master that never raises both strobes at once.
`default_nettype none
module ccpu_unit_props
	import ccpu_pkg::*;
(
	// clock and reset
	input wire logic        mclk_i,
	input wire logic        rst_n_i,
	// register port
	input wire logic [7:0]  addr_i,
	input wire logic [7:0]  wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [7:0]  rdata_o,
	// timer one, converter, pins
	input wire logic [15:0] timer_one_count_i,
	input wire logic        ad_enable_i,
	input wire logic        timer_one_reset_o,
	input wire logic        ad_start_o,
	input wire logic [1:0]  channel_pin_i,
	input wire logic [1:0]  channel_pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] period_q; // period register shadow
	logic [5:0] con_q;    // channel one control shadow
	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);
	// shadows follow software writes
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			period_q <= RST_PR2;
			con_q <= RST_CON;
		end else if (wr_i && addr_i == OFF_PR2) begin
			period_q <= wdata_i;
		end else if (wr_i && addr_i == OFF_CH_CON[0]) begin
			con_q <= wdata_i[5:0];
		end
	end
	idle_read_a: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data not zero outside a read");
	unmapped_read_a: assert property (rd_i && addr_i == 8'h00 |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	timer_ctl_top_a: assert property (rd_i && addr_i == OFF_TIMER_TWO_CONTROL |=> !rdata_o[7])
		else $error("timer two control top bit not zero");
	period_read_a: assert property (rd_i && addr_i == OFF_PR2 |=> rdata_o == period_q)
		else $error("period register read wrong");
	control_read_a: assert property (
		rd_i && addr_i == OFF_CH_CON[0] |=> rdata_o == {2'b00, con_q})
		else $error("control read wrong");
	mode_off_pin_a: assert property (
		wr_i && addr_i == OFF_CH_CON[0] && wdata_i[3:0] == 4'h0 |-> ##[1:3] !channel_pin_o[0])
		else $error("pin not low after disable");
	trigger_pulse_a: assert property ($rose(timer_one_reset_o) |=> !timer_one_reset_o)
		else $error("timer one reset longer than one cycle");
	convert_gate_a: assert property (ad_start_o |-> $past(ad_enable_i))
		else $error("converter start while converter disabled");
	convert_single_a: assert property (ad_start_o |=> !ad_start_o)
		else $error("converter start longer than one cycle");
endmodule : ccpu_unit_props
bind ccpu_unit ccpu_unit_props u_props (
	.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
	.rd_i(rd_i), .rdata_o(rdata_o), .timer_one_count_i(timer_one_count_i),
	.ad_enable_i(ad_enable_i), .timer_one_reset_o(timer_one_reset_o), .ad_start_o(ad_start_o),
	.channel_pin_i(channel_pin_i), .channel_pin_o(channel_pin_o)
);
`default_nettype wire

// ### verif/ccpu_pin_model.sv
// pad source for the two channel pins: one high pulse per request.
// assumes requests last one cycle and come only while the pin is idle.
`default_nettype none
module ccpu_pin_model (
	// clock and reset
	input  wire logic       mclk_i,
	input  wire logic       rst_n_i,
	// pulse request per pin
	input  wire logic [1:0] req_i,
	// pad levels
	output logic      [1:0] pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_q [2]; // cycles left in each pulse
	always_ff @(posedge mclk_i) begin
		for (int c = 0; c < 2; c++) begin
			if (!rst_n_i) begin
				cnt_q[c] <= 4'h0;
			end else if (req_i[c]) begin
				cnt_q[c] <= 4'h8;
			end else if (cnt_q[c] != 4'h0) begin
				cnt_q[c] <= cnt_q[c] - 4'h1;
			end
		end
	end
	// four cycles high, then low: each level outlasts the synchroniser
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			pin_o[c] = cnt_q[c] > 4'h4;
		end
	end
endmodule : ccpu_pin_model
`default_nettype wire

// ### verif/ccpu_unit_bench.sv
// self-checking bench for the capture/compare/pwm unit.
// assumes the pin model answers in a fixed number of cycles.
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin err_count++; \
	$display("unexpected %s expected %h seen %h", nm, ex, got); end end
module ccpu_unit_bench
	import ccpu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk = 1'b0;     // 250 MHz clock
	logic        rst_n = 1'b0;    // reset, active low
	logic [7:0]  addr = 8'h00;    // register address
	logic [7:0]  wdata = 8'h00;   // write data
	logic        wr = 1'b0;       // write strobe
	logic        rd = 1'b0;       // read strobe
	logic [7:0]  rdata;           // read data
	logic [15:0] tcnt = 16'h0000; // timer one count
	logic        ad_en = 1'b0;    // converter enable
	logic        t1_rst;          // timer one reset pulse
	logic        ad_start;        // converter start pulse
	logic [1:0]  pin_in;          // pad levels
	logic [1:0]  pin_out;         // channel outputs
	logic [1:0]  req = 2'b00;     // pulse requests to the pin model
	logic [7:0]  hi0;             // high cycles, channel one
	logic [7:0]  hi1;             // high cycles, channel two
	int          err_count = 0;
	int          checks = 0;
	localparam logic [7:0] flag_off [2] = '{OFF_PERIPHERAL_IRQ_FLAGS_ONE, OFF_FLAGS_TWO};
	localparam logic [7:0] flag_set [2] = '{8'h04, 8'h01};
	localparam int         cap_cnt  [4] = '{1, 1, 4, 16};
	localparam logic [7:0] rst_addr [13] = '{OFF_PERIPHERAL_IRQ_FLAGS_ONE, OFF_FLAGS_TWO, OFF_TIMER_TWO_COUNT, OFF_TIMER_TWO_CONTROL,
		OFF_PERIPHERAL_IRQ_ENABLES_ONE, OFF_PR2, OFF_CH_LO[0], OFF_CH_HI[0], OFF_CH_CON[0], OFF_CH_LO[1],
		OFF_CH_HI[1], OFF_CH_CON[1], 8'h00};
	// compare steps: channel, control, watched outputs, expected outputs
	localparam int         cmp_ch  [7] = '{0, 0, 0, 0, 0, 0, 1};
	localparam logic [7:0] cmp_con [7] = '{8'h08, 8'h0A, 8'h09, 8'h08, 8'h00, 8'h0B, 8'h0B};
	localparam logic [3:0] cmp_msk [7] = '{4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h4, 4'h8};
	localparam logic [3:0] cmp_val [7] = '{4'h1, 4'h1, 4'h0, 4'h1, 4'h0, 4'h4, 4'h8};
	ccpu_unit DUT (
		.mclk_i(mclk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .timer_one_count_i(tcnt), .ad_enable_i(ad_en),
		.timer_one_reset_o(t1_rst), .ad_start_o(ad_start), .channel_pin_i(pin_in),
		.channel_pin_o(pin_out)
	);
	ccpu_pin_model u_pins (.mclk_i(mclk), .rst_n_i(rst_n), .req_i(req), .pin_o(pin_in));
	// verdict and end of run
	task automatic print_verdict();
		if (err_count == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : print_verdict
	// one write cycle
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wr_reg
	// one read cycle, data checked in the cycle after the strobe
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		`CHK($sformatf("register %h", a), e, rdata)
	endtask : rd_chk
	// bounded wait on pins and pulses
	task automatic wait_obs(input logic [3:0] m, input logic [3:0] v);
		int n = 0;
		while (({ad_start, t1_rst, pin_out} & m) !== v) begin
			@(posedge mclk);
			#1;
			n++;
			if (n > 20) begin
				`CHK("pins and pulses", v, {ad_start, t1_rst, pin_out} & m)
				print_verdict();
			end
		end
		checks++;
	endtask : wait_obs
	// one high pulse on a channel pin
	task automatic pulse(input int ch);
		@(posedge mclk);
		req <= 2'b01 << ch;
		@(posedge mclk);
		req <= 2'b00;
		repeat (14) @(posedge mclk);
	endtask : pulse
	// capture after n pulses, none before
	task automatic cap(input int ch, input logic [3:0] m, input int n);
		wr_reg(OFF_CH_CON[ch], 8'h00);
		wr_reg(OFF_CH_CON[ch], {4'h0, m});
		wr_reg(flag_off[ch], 8'h00);
		@(posedge mclk);
		tcnt <= 16'h5A5A;
		for (int i = 1; i < n; i++) pulse(ch);
		rd_chk(flag_off[ch], 8'h00);
		@(posedge mclk);
		tcnt <= {4'hC, m, n[7:0]};
		pulse(ch);
		rd_chk(OFF_CH_LO[ch], n[7:0]);
		rd_chk(OFF_CH_HI[ch], {4'hC, m});
		rd_chk(flag_off[ch], flag_set[ch]);
	endtask : cap
	// main sequence
	initial begin
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		foreach (rst_addr[i]) rd_chk(rst_addr[i], rst_addr[i] == OFF_PR2 ? RST_PR2 : 8'h00);
		wr_reg(OFF_CH_CON[0], 8'hFF);
		rd_chk(OFF_CH_CON[0], 8'h3F);
		wr_reg(OFF_TIMER_TWO_CONTROL, 8'hFF);
		rd_chk(OFF_TIMER_TWO_CONTROL, 8'h7F);
		wr_reg(OFF_TIMER_TWO_CONTROL, 8'h00);
		wr_reg(OFF_PERIPHERAL_IRQ_ENABLES_ONE, 8'hA5);
		wr_reg(8'h00, 8'hFF);
		rd_chk(OFF_PERIPHERAL_IRQ_ENABLES_ONE, 8'hA5);
		rd_chk(8'h00, 8'h00);
		for (int k = 0; k < 4; k++) cap(0, MODE_CAP_FALL + 4'(k), cap_cnt[k]);
		cap(1, 4'h5, 1);
		@(posedge mclk);
		tcnt <= 16'h2222;
		pulse(1);
		rd_chk(OFF_CH_LO[1], 8'h22);
		ad_en <= 1'b1;
		for (int k = 0; k < 7; k++) begin
			@(posedge mclk);
			tcnt <= 16'h0000;
			wr_reg(OFF_CH_CON[cmp_ch[k]], cmp_con[k]);
			wr_reg(OFF_CH_LO[cmp_ch[k]], 8'h34);
			wr_reg(OFF_CH_HI[cmp_ch[k]], 8'h12);
			wr_reg(flag_off[cmp_ch[k]], 8'h00);
			@(posedge mclk);
			tcnt <= 16'h1234;
			wait_obs(cmp_msk[k], cmp_val[k]);
			repeat (3) @(posedge mclk);
			rd_chk(flag_off[cmp_ch[k]], cmp_con[k] == 8'h00 ? 8'h00 : flag_set[cmp_ch[k]]);
			`CHK("pin level", cmp_val[k][1:0], pin_out & cmp_msk[k][1:0])
		end
		wr_reg(OFF_TIMER_TWO_COUNT, 8'h00);
		wr_reg(OFF_PR2, 8'h03);
		wr_reg(OFF_CH_LO[0], 8'h02);
		wr_reg(OFF_CH_CON[0], 8'h0C);
		wr_reg(OFF_CH_LO[1], 8'h01);
		wr_reg(OFF_CH_CON[1], 8'h3C);
		wr_reg(OFF_TIMER_TWO_CONTROL, 8'h04);
		repeat (40) @(posedge mclk);
		hi0 = 8'h00;
		hi1 = 8'h00;
		for (int i = 0; i < 32; i++) begin
			@(posedge mclk);
			#1;
			hi0 += {7'h00, pin_out[0]};
			hi1 += {7'h00, pin_out[1]};
		end
		// the clear is registered: duty n gives n+1 high cycles per period
		`CHK("channel one high cycles", 8'h12, hi0)
		`CHK("channel two high cycles", 8'h10, hi1)
		wr_reg(OFF_CH_HI[0], 8'h55);
		rd_chk(OFF_CH_HI[0], 8'h02);
		print_verdict();
	end
	// clock
	initial begin
		forever #2 mclk = ~mclk;
	end
endmodule : ccpu_unit_bench
`undef CHK
`default_nettype wire
